// ==== ufc_pkg.sv ====
// package: register map, field layout and reset values of the ulpi function/interface control bank
package ufc_pkg;

   // *****************************************************************
   // register addresses
   // *****************************************************************
   localparam logic [5:0] FUNC_WR_ADDR  = 6'h04;
   localparam logic [5:0] FUNC_SET_ADDR = 6'h05;
   localparam logic [5:0] FUNC_CLR_ADDR = 6'h06;
   localparam logic [5:0] INTF_WR_ADDR  = 6'h07;
   localparam logic [5:0] INTF_SET_ADDR = 6'h08;
   localparam logic [5:0] INTF_CLR_ADDR = 6'h09;

   // *****************************************************************
   // reset values
   // *****************************************************************
   localparam logic [7:0] FUNC_RESET    = 8'h41;
   localparam logic [7:0] INTF_RESET    = 8'h00;
   localparam logic [7:0] INTF_RSVD_MASK = 8'h10;

   // *****************************************************************
   // field encodings
   // *****************************************************************
   localparam logic [1:0] ENC_NORMAL     = 2'h0;
   localparam logic [1:0] ENC_NONDRIVE   = 2'h1;
   localparam logic [1:0] ENC_RAW        = 2'h2;
   localparam logic [1:0] ENC_NO_SYNCEOP = 2'h3;
   localparam logic [1:0] SPD_HS         = 2'h0;
   localparam logic [1:0] SPD_FS         = 2'h1;
   localparam logic [1:0] SPD_LS         = 2'h2;
   localparam logic [1:0] SPD_LS_ON_FS   = 2'h3;

   typedef enum logic [1:0]
   {
      UFC_OP_WRITE = 2'h0,
      UFC_OP_SET   = 2'h1,
      UFC_OP_CLEAR = 2'h2,
      UFC_OP_NONE  = 2'h3
   } ufc_op_t;

   typedef struct packed
   {
      logic       reserved;
      logic       phy_low_power_n;
      logic       core_reset;
      logic [1:0] tx_encoding_select;
      logic       termination_select;
      logic [1:0] transceiver_speed_select;
   } ufc_func_t;

   typedef struct packed
   {
      logic interface_protect_disable;
      logic indicator_passthrough;
      logic indicator_invert;
      logic reserved;
      logic serial_clock_power_n;
      logic carkit_mode;
      logic three_wire_serial_mode;
      logic six_wire_serial_mode;
   } ufc_intf_t;

   // transceiver controls derived from the function register
   typedef struct packed
   {
      logic hs_xcvr_en;
      logic fs_xcvr_en;
      logic ls_xcvr_en;
      logic fs_preamble_en;
      logic tx_drive_en;
      logic bitstuff_nrzi_en;
      logic auto_sync_eop_en;
      logic fs_pullup_en;
      logic hs_term_en;
   } ufc_xcvr_t;

endpackage

// ==== ufc_reg_update.sv ====
// one register: write, set and clear update against the bus pattern
`timescale 1ns/1ps
`default_nettype none
module ufc_reg_update #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] FIXED_MASK = 8'h00
)(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire ufc_pkg::ufc_op_t     op,
   input  wire logic [7:0]           wdata,
   input  wire logic                 hw_clr_en,
   input  wire logic [7:0]           hw_clr_mask,
   output logic      [7:0]           value
);

   logic [7:0] value_q;
   logic [7:0] value_d;

   always_comb
   begin
      unique case (op)
         ufc_pkg::UFC_OP_WRITE: value_d = wdata;
         ufc_pkg::UFC_OP_SET:   value_d = value_q | wdata;
         ufc_pkg::UFC_OP_CLEAR: value_d = value_q & ~wdata;
         ufc_pkg::UFC_OP_NONE:  value_d = value_q;
      endcase
      // hardware self-clear applies after software update
      if (hw_clr_en)
      begin
         value_d = value_d & ~hw_clr_mask;
      end
      value_d = value_d & ~FIXED_MASK;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         value_q <= RESET_VAL;
      end
      else
      begin
         value_q <= value_d;
      end
   end

   assign value = value_q;

endmodule
`default_nettype wire

// ==== ufc_decode.sv ====
// combinational decode of transceiver and pad controls from the two registers
`timescale 1ns/1ps
`default_nettype none
module ufc_decode (
   input  wire ufc_pkg::ufc_func_t   func,
   input  wire ufc_pkg::ufc_intf_t   intf,
   input  wire logic                 dplus_pulldown_enable,
   input  wire logic                 dminus_pulldown_enable,
   input  wire logic                 stp_in,
   input  wire logic                 fault_in,
   input  wire logic                 vbus_valid_comparator,
   output ufc_pkg::ufc_xcvr_t        xcvr,
   output logic                      stp_pullup_en,
   output logic                      data_pulldown_en,
   output logic                      vbus_state,
   output logic                      clock_power_en,
   output logic                      low_power_en
);

   logic host_mode;
   logic serial_mode;
   logic fault_compl;

   always_comb
   begin
      host_mode   = dplus_pulldown_enable & dminus_pulldown_enable;
      serial_mode = intf.three_wire_serial_mode | intf.six_wire_serial_mode;
      xcvr = '0;
      unique case (func.transceiver_speed_select)
         ufc_pkg::SPD_HS:       xcvr.hs_xcvr_en = 1'b1;
         ufc_pkg::SPD_FS:       xcvr.fs_xcvr_en = 1'b1;
         ufc_pkg::SPD_LS:       xcvr.ls_xcvr_en = 1'b1;
         ufc_pkg::SPD_LS_ON_FS:
         begin
            xcvr.fs_xcvr_en     = 1'b1;
            xcvr.fs_preamble_en = 1'b1;
         end
      endcase
      xcvr.tx_drive_en      = func.tx_encoding_select != ufc_pkg::ENC_NONDRIVE;
      // only the raw setting drops stuffing and nrzi; non-driving stops the drivers and the hs terms
      xcvr.bitstuff_nrzi_en = func.tx_encoding_select != ufc_pkg::ENC_RAW;
      xcvr.auto_sync_eop_en = func.tx_encoding_select != ufc_pkg::ENC_NO_SYNCEOP;
      // termination: hs terms when term select low in hs, fs pull-up only as a peripheral
      xcvr.hs_term_en   = !func.termination_select && xcvr.hs_xcvr_en
                       && func.tx_encoding_select != ufc_pkg::ENC_NONDRIVE;
      xcvr.fs_pullup_en = func.termination_select && !host_mode
                       && func.tx_encoding_select != ufc_pkg::ENC_RAW;
      // protection: pull-up always while enabled, pull-downs only on a floating stp
      stp_pullup_en    = !intf.interface_protect_disable;
      data_pulldown_en = !intf.interface_protect_disable && stp_in;
      fault_compl = fault_in ^ intf.indicator_invert;
      vbus_state  = intf.indicator_passthrough ? fault_compl
                                               : (fault_compl & vbus_valid_comparator);
      low_power_en = !func.phy_low_power_n;
      // the clock bit only counts in serial modes while the phy is powered
      clock_power_en = (serial_mode && func.phy_low_power_n)
                     ? intf.serial_clock_power_n : !intf.carkit_mode;
   end

endmodule
`default_nettype wire

// ==== ufc_ctrl_bank.sv ====
// top: function and interface control registers with ulpi register access
`timescale 1ns/1ps
`default_nettype none

// *****************************************************************
// register bank
// *****************************************************************
// Contract
// - encoding field selects normal, non-driving, raw
// - encoding 11b drops automatic sync and eop
// - termination bit drives pull-up and hs terms
// - speed field picks hs, fs, ls transceiver
// - speed 11b sends ls via fs with preamble
// - function reg: write 04h, set 05h, clear 06h
// - interface reg: write 07h, set 08h, clear 09h
// - set ors, clear masks, write replaces
// - protection: stp pull-up, data pull-downs on float
// - protection detects link releasing stp and data; code senses stp_in only
// - protect disable removes all weak pulls
// - passthrough skips vbus valid qualification
// - invert bit complements the fault input
// - clock bit powers clock in serial modes
// - clock bit honoured only in serial, powered
// - phy low-power bit zero powers down blocks
module ufc_ctrl_bank (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // ulpi register access, already parsed from the link command
   input  wire logic                 reg_wr_en,
   input  wire logic                 reg_rd_en,
   input  wire logic [5:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   output logic                      reg_rd_valid,
   // self-clear requests from the phy core
   input  wire logic                 low_power_exit,
   input  wire logic                 core_reset_done,
   input  wire logic                 serial_mode_exit,
   // analog and pad side
   input  wire logic                 dplus_pulldown_enable,
   input  wire logic                 dminus_pulldown_enable,
   input  wire logic                 stp_in,
   input  wire logic                 fault_in,
   input  wire logic                 vbus_valid_comparator,
   output ufc_pkg::ufc_xcvr_t        xcvr_ctrl,
   output logic                      stp_pullup_en,
   output logic                      data_pulldown_en,
   output logic                      vbus_state,
   output logic                      clock_power_en,
   output logic                      low_power_en,
   output logic                      core_reset_req,
   output logic                      three_wire_serial_mode,
   output logic                      six_wire_serial_mode
);

   // *****************************************************************
   // address decode
   // *****************************************************************
   function automatic ufc_pkg::ufc_op_t op_of(input logic [5:0] a, input logic [5:0] base);
      ufc_pkg::ufc_op_t r;
      r = ufc_pkg::UFC_OP_NONE;
      if (a == base)
      begin
         r = ufc_pkg::UFC_OP_WRITE;
      end
      else if (a == base + 6'h01)
      begin
         r = ufc_pkg::UFC_OP_SET;
      end
      else if (a == base + 6'h02)
      begin
         r = ufc_pkg::UFC_OP_CLEAR;
      end
      return r;
   endfunction

   localparam logic [7:0] FUNC_POWERED_MASK = 8'h40;

   ufc_pkg::ufc_op_t  func_op;
   logic [7:0]        func_wdata;
   ufc_pkg::ufc_op_t  intf_op;
   logic [7:0]        func_val;
   logic [7:0]        intf_val;
   logic [7:0]        func_hw_mask;
   logic [7:0]        intf_hw_mask;
   ufc_pkg::ufc_xcvr_t xcvr_d;
   logic              stp_pullup_d;
   logic              data_pulldown_d;
   logic              vbus_state_d;
   logic              clock_power_d;
   logic              low_power_d;

   always_comb
   begin
      func_op = reg_wr_en ? op_of(reg_addr, ufc_pkg::FUNC_WR_ADDR) : ufc_pkg::UFC_OP_NONE;
      intf_op = reg_wr_en ? op_of(reg_addr, ufc_pkg::INTF_WR_ADDR) : ufc_pkg::UFC_OP_NONE;
      // a wake-up must set the powered bit whatever the link does in the same cycle
      func_wdata = reg_wdata;
      if (low_power_exit)
      begin
         unique case (func_op)
            ufc_pkg::UFC_OP_WRITE,
            ufc_pkg::UFC_OP_SET:   func_wdata = reg_wdata | FUNC_POWERED_MASK;
            ufc_pkg::UFC_OP_CLEAR:
            begin
               func_op    = ufc_pkg::UFC_OP_WRITE;
               func_wdata = (func_val & ~reg_wdata) | FUNC_POWERED_MASK;
            end
            ufc_pkg::UFC_OP_NONE:
            begin
               func_op    = ufc_pkg::UFC_OP_SET;
               func_wdata = FUNC_POWERED_MASK;
            end
         endcase
      end
      // self-clear: suspend bit set on exit, reset bit cleared when done
      func_hw_mask = {1'b0, 1'b0, core_reset_done, 5'h00};
      intf_hw_mask = {5'h00, 1'b0, serial_mode_exit, serial_mode_exit};
   end

   // *****************************************************************
   // registers
   // *****************************************************************
   ufc_reg_update #(
      .RESET_VAL  (ufc_pkg::FUNC_RESET),
      .FIXED_MASK (8'h00)
   ) u_func (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .op          (func_op),
      .wdata       (func_wdata),
      .hw_clr_en   (core_reset_done),
      .hw_clr_mask (func_hw_mask),
      .value       (func_val)
   );

   ufc_reg_update #(
      .RESET_VAL  (ufc_pkg::INTF_RESET),
      .FIXED_MASK (ufc_pkg::INTF_RSVD_MASK)
   ) u_intf (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .op          (intf_op),
      .wdata       (reg_wdata),
      .hw_clr_en   (serial_mode_exit),
      .hw_clr_mask (intf_hw_mask),
      .value       (intf_val)
   );

   // *****************************************************************
   // readback
   // *****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         reg_rdata    <= 8'h00;
         reg_rd_valid <= 1'b0;
      end
      else
      begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en)
         begin
            if (op_of(reg_addr, ufc_pkg::FUNC_WR_ADDR) != ufc_pkg::UFC_OP_NONE)
            begin
               reg_rdata <= func_val;
            end
            else if (op_of(reg_addr, ufc_pkg::INTF_WR_ADDR) != ufc_pkg::UFC_OP_NONE)
            begin
               reg_rdata <= intf_val & ~ufc_pkg::INTF_RSVD_MASK;
            end
            else
            begin
               reg_rdata <= 8'h00;
            end
         end
      end
   end

   // *****************************************************************
   // decoded controls, registered so outputs come from flops
   // *****************************************************************
   ufc_decode u_dec (
      .func                   (ufc_pkg::ufc_func_t'(func_val)),
      .intf                   (ufc_pkg::ufc_intf_t'(intf_val)),
      .dplus_pulldown_enable  (dplus_pulldown_enable),
      .dminus_pulldown_enable (dminus_pulldown_enable),
      .stp_in                 (stp_in),
      .fault_in               (fault_in),
      .vbus_valid_comparator  (vbus_valid_comparator),
      .xcvr                   (xcvr_d),
      .stp_pullup_en          (stp_pullup_d),
      .data_pulldown_en       (data_pulldown_d),
      .vbus_state             (vbus_state_d),
      .clock_power_en         (clock_power_d),
      .low_power_en           (low_power_d)
   );

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         xcvr_ctrl              <= '0;
         stp_pullup_en          <= 1'b1;
         data_pulldown_en       <= 1'b0;
         vbus_state             <= 1'b0;
         clock_power_en         <= 1'b1;
         low_power_en           <= 1'b0;
         core_reset_req         <= 1'b0;
         three_wire_serial_mode <= 1'b0;
         six_wire_serial_mode   <= 1'b0;
      end
      else
      begin
         xcvr_ctrl              <= xcvr_d;
         stp_pullup_en          <= stp_pullup_d;
         data_pulldown_en       <= data_pulldown_d;
         vbus_state             <= vbus_state_d;
         clock_power_en         <= clock_power_d;
         low_power_en           <= low_power_d;
         core_reset_req         <= func_val[5];
         // the link must not enable both serial modes together
         three_wire_serial_mode <= intf_val[1];
         six_wire_serial_mode   <= intf_val[0];
      end
   end

endmodule
`default_nettype wire

// ==== ufc_link_model.sv ====
// link model: issues ulpi register accesses toward the control bank
`timescale 1ns/1ps
`default_nettype none
module ufc_link_model (
   input  wire logic       clk_sys,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic [5:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rd_valid
);
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 6'h3F;
      reg_wdata = 8'hA5;
   end

   // entered at a falling edge; the request stands over the next rising edge
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_wr_en = 1'b1;
      reg_rd_en = 1'b0;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
   endtask

   // data lines are a don't-care on reads, so they are scrambled
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b1;
      reg_addr  = a;
      reg_wdata = ~reg_wdata;
      @(negedge clk_sys);
      d = reg_rdata;
      v = reg_rd_valid;
   endtask

   task automatic idle(input int n);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      repeat (n) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

// ==== ufc_ctrl_bank_sva.sv ====
// checker: port-level assertions for the control bank
`timescale 1ns/1ps
`default_nettype none
module ufc_ctrl_bank_sva (
   input wire logic               clk_sys,
   input wire logic               rst_b,
   input wire logic               reg_wr_en,
   input wire logic               reg_rd_en,
   input wire logic [5:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic [7:0]         reg_rdata,
   input wire logic               reg_rd_valid,
   input wire logic               serial_mode_exit,
   input wire ufc_pkg::ufc_xcvr_t xcvr_ctrl,
   input wire logic               stp_pullup_en,
   input wire logic               data_pulldown_en,
   input wire logic               low_power_en,
   input wire logic               three_wire_serial_mode,
   input wire logic               six_wire_serial_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_func_wr;
      reg_wr_en && reg_addr == ufc_pkg::FUNC_WR_ADDR;
   endsequence
   sequence s_intf_wr;
      reg_wr_en && reg_addr == ufc_pkg::INTF_WR_ADDR;
   endsequence
   sequence s_func_rd;
      reg_rd_en && !reg_wr_en && reg_addr inside {[6'h04:6'h06]};
   endsequence
   sequence s_intf_rd;
      reg_rd_en && !reg_wr_en && reg_addr inside {[6'h07:6'h09]};
   endsequence

   a_rd_valid_follows: assert property (reg_rd_en |=> reg_rd_valid)
      else $error("read not answered");
   a_rd_valid_single: assert property (reg_rd_en ##1 !reg_rd_en |=> !reg_rd_valid)
      else $error("read valid too long");
   a_rdata_held: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (reg_rd_en && !(reg_addr inside {[6'h04:6'h09]}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_func_readback: assert property (s_func_wr ##1 s_func_rd |=> reg_rdata == $past(reg_wdata, 2))
      else $error("function register readback wrong");
   a_intf_readback: assert property (s_intf_wr ##1 s_intf_rd |=> reg_rdata == ($past(reg_wdata, 2) & ~ufc_pkg::INTF_RSVD_MASK))
      else $error("interface register readback wrong");
   a_sync_eop_ctrl: assert property (s_func_wr |-> ##2 xcvr_ctrl.auto_sync_eop_en == ($past(reg_wdata[4:3], 2) != ufc_pkg::ENC_NO_SYNCEOP))
      else $error("sync eop control wrong");
   a_speed_ctrl: assert property (s_func_wr |-> ##2 xcvr_ctrl.hs_xcvr_en == ($past(reg_wdata[1:0], 2) == ufc_pkg::SPD_HS)
                                 && xcvr_ctrl.fs_preamble_en == ($past(reg_wdata[1:0], 2) == ufc_pkg::SPD_LS_ON_FS))
      else $error("speed control wrong");
   a_low_power: assert property (s_func_wr |-> ##2 low_power_en == !$past(reg_wdata[6], 2))
      else $error("low power control wrong");
   a_stp_pullup: assert property (s_intf_wr |-> ##2 stp_pullup_en == !$past(reg_wdata[7], 2))
      else $error("stp pull-up control wrong");
   a_pulldown_guard: assert property (data_pulldown_en |-> stp_pullup_en)
      else $error("pull-downs without protection");
   a_serial_exit: assert property (serial_mode_exit |-> ##[1:2] (!three_wire_serial_mode && !six_wire_serial_mode))
      else $error("serial mode not left");
endmodule

bind ufc_ctrl_bank ufc_ctrl_bank_sva u_sva (
   .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
   .serial_mode_exit(serial_mode_exit), .xcvr_ctrl(xcvr_ctrl), .stp_pullup_en(stp_pullup_en),
   .data_pulldown_en(data_pulldown_en), .low_power_en(low_power_en),
   .three_wire_serial_mode(three_wire_serial_mode), .six_wire_serial_mode(six_wire_serial_mode)
);
`default_nettype wire

// ==== ufc_ctrl_bank_tb_top.sv ====
// testbench: register access and decoded controls of the control bank
`timescale 1ns/1ps
`default_nettype none
module ufc_ctrl_bank_tb_top;
   logic clk_sys, rst_b, reg_wr_en, reg_rd_en, reg_rd_valid, stp_in, fault_in, vbus_valid_comparator;
   logic dplus_pulldown_enable, dminus_pulldown_enable, serial_mode_exit, stp_pullup_en, data_pulldown_en;
   logic vbus_state, clock_power_en, low_power_en, core_reset_req, three_wire_serial_mode, six_wire_serial_mode;
   logic low_power_exit, core_reset_done;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   ufc_pkg::ufc_xcvr_t xcvr_ctrl;
   int fails, check_count, cyc;

   ufc_ctrl_bank uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .low_power_exit(low_power_exit), .core_reset_done(core_reset_done), .serial_mode_exit(serial_mode_exit),
      .dplus_pulldown_enable(dplus_pulldown_enable), .dminus_pulldown_enable(dminus_pulldown_enable),
      .stp_in(stp_in), .fault_in(fault_in), .vbus_valid_comparator(vbus_valid_comparator),
      .xcvr_ctrl(xcvr_ctrl), .stp_pullup_en(stp_pullup_en), .data_pulldown_en(data_pulldown_en),
      .vbus_state(vbus_state), .clock_power_en(clock_power_en), .low_power_en(low_power_en),
      .core_reset_req(core_reset_req), .three_wire_serial_mode(three_wire_serial_mode),
      .six_wire_serial_mode(six_wire_serial_mode)
   );

   ufc_link_model link (
      .clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a hang is cut short well past the roughly 470 cycles the tests need
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         conclude();
      end
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      link.rd(a, d, v);
      chk({v, d}, {1'b1, e});
   endtask

   task automatic t_reset();
      rdc(ufc_pkg::FUNC_WR_ADDR, ufc_pkg::FUNC_RESET);
      rdc(ufc_pkg::INTF_WR_ADDR, ufc_pkg::INTF_RESET);
      chk({5'h0, stp_pullup_en, clock_power_en, low_power_en, data_pulldown_en}, 9'h00C);
      $display("t_reset done");
   endtask

   task automatic t_access();
      link.wr(ufc_pkg::FUNC_WR_ADDR, 8'h49);
      rdc(ufc_pkg::FUNC_WR_ADDR, 8'h49);
      link.wr(ufc_pkg::FUNC_SET_ADDR, 8'h16);
      link.wr(ufc_pkg::FUNC_CLR_ADDR, 8'h0C);
      for (int a = 4; a < 7; a++) rdc(6'(a), 8'h53);
      link.wr(ufc_pkg::INTF_WR_ADDR, 8'hF9);
      rdc(ufc_pkg::INTF_WR_ADDR, 8'hE9);
      link.wr(ufc_pkg::INTF_CLR_ADDR, 8'h01);
      link.wr(ufc_pkg::INTF_SET_ADDR, 8'h12);
      for (int a = 7; a < 10; a++) rdc(6'(a), 8'hEA);
      link.wr(6'h0A, 8'hFF);
      rdc(6'h0A, 8'h00);
      rdc(ufc_pkg::FUNC_SET_ADDR, 8'h53);
      serial_mode_exit = 1'b1;
      link.idle(1);
      serial_mode_exit = 1'b0;
      rdc(ufc_pkg::INTF_CLR_ADDR, 8'hE8);
      $display("t_access done");
   endtask

   // self-clear and wake-up pulses against link accesses in the same cycle
   task automatic t_selfclear();
      link.wr(ufc_pkg::FUNC_WR_ADDR, 8'h01);
      link.wr(ufc_pkg::FUNC_SET_ADDR, 8'h20);
      link.idle(2);
      chk({7'h0, core_reset_req, low_power_en}, 9'h003);
      low_power_exit  = 1'b1;
      core_reset_done = 1'b1;
      link.wr(ufc_pkg::FUNC_CLR_ADDR, 8'h41);
      low_power_exit  = 1'b0;
      core_reset_done = 1'b0;
      rdc(ufc_pkg::FUNC_WR_ADDR, 8'h40);
      link.wr(ufc_pkg::FUNC_CLR_ADDR, 8'h40);
      low_power_exit = 1'b1;
      link.idle(1);
      low_power_exit = 1'b0;
      rdc(ufc_pkg::FUNC_SET_ADDR, 8'h40);
      link.idle(2);
      chk({7'h0, core_reset_req, low_power_en}, 9'h000);
      $display("t_selfclear done");
   endtask

   task automatic t_decode();
      ufc_pkg::ufc_xcvr_t e;
      logic [5:0]         v;
      for (int i = 0; i < 64; i++)
      begin
         v = 6'(i);
         dplus_pulldown_enable  = v[5];
         dminus_pulldown_enable = v[5];
         link.wr(ufc_pkg::FUNC_WR_ADDR, {3'h2, v[4:0]});
         link.idle(2);
         e.hs_xcvr_en       = v[1:0] == ufc_pkg::SPD_HS;
         e.fs_xcvr_en       = v[0];
         e.ls_xcvr_en       = v[1:0] == ufc_pkg::SPD_LS;
         e.fs_preamble_en   = v[1:0] == ufc_pkg::SPD_LS_ON_FS;
         e.tx_drive_en      = v[4:3] != ufc_pkg::ENC_NONDRIVE;
         e.bitstuff_nrzi_en = v[4:3] != 2'h2;
         e.auto_sync_eop_en = v[4:3] != ufc_pkg::ENC_NO_SYNCEOP;
         e.fs_pullup_en     = v[2] && !v[5] && v[4:3] != ufc_pkg::ENC_RAW;
         e.hs_term_en       = !v[2] && e.hs_xcvr_en && e.tx_drive_en;
         chk(xcvr_ctrl, e);
      end
      $display("t_decode done");
   endtask

   task automatic t_protect();
      logic [5:0] v;
      for (int i = 0; i < 64; i++)
      begin
         v = 6'(i);
         stp_in                = v[2];
         fault_in              = v[1];
         vbus_valid_comparator = v[0];
         link.wr(ufc_pkg::INTF_WR_ADDR, {v[5:3], 5'h00});
         link.idle(2);
         chk({6'h0, stp_pullup_en, data_pulldown_en, vbus_state},
             {6'h0, !v[5], !v[5] && v[2], (v[1] ^ v[3]) && (v[4] || v[0])});
      end
      $display("t_protect done");
   endtask

   task automatic t_clock();
      logic [3:0] v;
      for (int i = 0; i < 16; i++)
      begin
         v  = 4'(i);
         if (v[1:0] != 2'h3)
         begin
            link.wr(ufc_pkg::FUNC_WR_ADDR, {1'b0, v[3], 6'h01});
            link.wr(ufc_pkg::INTF_WR_ADDR, {4'h0, v[2], 1'b0, v[1:0]});
            link.idle(2);
            chk({5'h0, clock_power_en, low_power_en, three_wire_serial_mode, six_wire_serial_mode},
                {5'h0, v[1:0] == 2'h0 || v[2] || !v[3], !v[3], v[1:0]});
         end
      end
      $display("t_clock done");
   endtask

   initial
   begin
      rst_b = 1'b0;
      stp_in = 1'b0;
      fault_in = 1'b0;
      vbus_valid_comparator = 1'b0;
      dplus_pulldown_enable = 1'b0;
      dminus_pulldown_enable = 1'b0;
      serial_mode_exit = 1'b0;
      low_power_exit = 1'b0;
      core_reset_done = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      t_reset();
      t_access();
      t_selfclear();
      t_decode();
      t_protect();
      t_clock();
      link.idle(2);
      conclude();
   end
endmodule
`default_nettype wire
